// ---- design/uoirs_defines.svh ----
/*
 Holds the register offsets, field positions and timing
 figures of the interrupt-status and role-reporting block.
 Assumes it is included by bare name wherever these constants are used.
*/
`ifndef UOIRS_DEFINES_SVH
`define UOIRS_DEFINES_SVH

// Register word addresses on the plain register port.
`define UOIRS_ADDR_COMBINED 4'h0
`define UOIRS_ADDR_CTRL_STAT 4'h1
`define UOIRS_ADDR_EP_STAT 4'h2
`define UOIRS_ADDR_CTRL_EN 4'h3
`define UOIRS_ADDR_EP_EN 4'h4
`define UOIRS_ADDR_COMB_EN 4'h5
`define UOIRS_ADDR_OTG_CTRL 4'h6
`define UOIRS_ADDR_ROLE 4'h7

// Control event bit positions.
`define UOIRS_EV_POWER_ERR 0
`define UOIRS_EV_SESS_BEGIN 1
`define UOIRS_EV_SESS_FINISH 2
`define UOIRS_EV_DETACH 3
`define UOIRS_EV_ATTACH 4
`define UOIRS_EV_FRAME_START 5
`define UOIRS_EV_OVERRUN 6
`define UOIRS_EV_BUS_RESET 7
`define UOIRS_EV_WAKEUP 8
`define UOIRS_EV_IDLE 9
`define UOIRS_EV_ROLE_FOUND 10
`define UOIRS_EV_SUPPLY_FAULT 11
`define UOIRS_NUM_EVENTS 12

// Combined view layout: four endpoints per class, status from bit 16 up.
`define UOIRS_COMB_EPS 4
`define UOIRS_COMB_HOST_IN_LSB 0
`define UOIRS_COMB_HOST_OUT_LSB 4
`define UOIRS_COMB_DEV_IN_LSB 8
`define UOIRS_COMB_DEV_OUT_LSB 12
`define UOIRS_COMB_STAT_LSB 16

// Combined enable bit positions, one per group.
`define UOIRS_CEN_HOST_IN 0
`define UOIRS_CEN_HOST_OUT 1
`define UOIRS_CEN_DEV_IN 2
`define UOIRS_CEN_DEV_OUT 3
`define UOIRS_CEN_STATUS 4
`define UOIRS_CEN_WIDTH 5

// Negotiation and transceiver control bits.
`define UOIRS_OC_NEG_EN 0
`define UOIRS_OC_PHY_OFF 1
`define UOIRS_OC_OTG_SESS 2
`define UOIRS_OC_BUS_RESET 3
`define UOIRS_OC_BUS_SUSPEND 4
`define UOIRS_OC_WIDTH 5

// Role codes: OTG in low bits, dual-role in bits 5:4.
`define UOIRS_DUAL_LSB 4

// Endpoint status word: host flags low half, device flags high half.
`define UOIRS_EP_DEV_LSB 16

// Least hold of the bus reset after a negotiated attach.
`define UOIRS_RESET_HOLD_MS 20
`define UOIRS_CLK_MHZ 125

`endif

// ---- design/uoirs_pkg.sv ----
/*
 Holds the types shared by the block's modules.
 Assumes the constant header is included first.
*/
package uoirs_pkg;
  typedef enum logic [2:0] {
    role_undetermined,
    role_a_host,
    role_a_peripheral,
    role_b_host,
    role_b_peripheral
  } uoirs_otg_role_type;

  typedef enum logic [1:0] {
    dual_none,
    dual_host,
    dual_device
  } uoirs_dual_role_type;

  typedef enum logic [1:0] {
    neg_idle,
    neg_armed,
    neg_attempt,
    neg_hosting
  } uoirs_neg_state_type;
endpackage

// ---- design/uoirs_flag_if.sv ----
/*
 Holds the carrier between the top module and its sticky flag banks.
 Assumes one clock shared by every party.
*/
`timescale 1ns/1ps
`default_nettype none
interface uoirs_flag_if #(parameter int W = 12);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] pend;
  modport bank (input set, input clr, output pend);
  modport user (output set, output clr, input pend);
endinterface
`default_nettype wire

// ---- design/uoirs_flag_bank.sv ----
/*
 Holds one bank of sticky event flags cleared by a read.
 Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module uoirs_flag_bank #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic reset,
  uoirs_flag_if.bank fl
);
  logic [W-1:0] pend_r;
  logic [W-1:0] pend_nxt;

  // A set arriving with the clear survives for the next read.
  assign pend_nxt = (pend_r & ~fl.clr) | fl.set; // R21
  assign fl.pend = pend_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- design/uoirs_top.sv ----
/*
 Holds the interrupt-status, role-reporting and host-negotiation logic
 of a dual-role bus controller, with a plain register port.
 Assumes event inputs are one-cycle pulses from core-clock logic, and
 that cable and bus level inputs come from pins and need synchronising.
*/
// Notes on behaviour
// R01: Sources grouped as IN, OUT endpoints and general; one combined read.
// R02: Reading the combined status clears all pending general status sources.
// R03: Combined view covers endpoints 0 to 3 only.
// R04: Control status read returns only control flags and clears them.
// R05: Endpoint status read returns host and device flags, clears them all.
// R06: Endpoint and control enables are separate; only enabled raise irq.
// R07: Power error, session begin, session finish, detach, attach events.
// R08: Frame start, overrun, bus reset, wakeup, idle events.
// R09: Role found event; supply fault event in host role.
// R10: OTG role reports A host, A peripheral, B host, B peripheral, none; the role logic never sets role_a_peripheral.
// R11: Session request without cable defaults role to B peripheral.
// R12: Role reads none while not determining the role.
// R13: Dual-role reports acting host, acting device, or inactive.
// R14: Negotiation enable for B-side peripheral; clearing it disables it.
// R15: Armed negotiation starts at the next observed bus suspend.
// R16: Successful negotiation raises attach and drives bus reset automatically.
// R17: Software holds the bus reset at least 20 ms after the attach.
// R18: Commanding bus suspend gives up the negotiated host role.
// R19: Transceiver off stops bus operation and lowers current.
// R20: Transceiver on out of reset; powering on restores normal operation.
// R21: An event arriving with a read clear stays pending.
`timescale 1ns/1ps
`default_nettype none
`include "uoirs_defines.svh"
module uoirs_top #(
  parameter int NUM_EP = 16,
  parameter bit OTG_CAPABLE = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [`UOIRS_NUM_EVENTS-1:0] ctrl_event,
  input wire logic [NUM_EP-1:0] host_in_event,
  input wire logic [NUM_EP-1:0] host_out_event,
  input wire logic [NUM_EP-1:0] dev_in_event,
  input wire logic [NUM_EP-1:0] dev_out_event,
  input wire logic cable_present,
  input wire logic cable_a_side,
  input wire logic bus_suspend_seen,
  input wire logic peer_attach_seen,
  output logic irq,
  output logic bus_reset_drive,
  output logic bus_suspend_drive,
  output logic phy_power_on,
  output logic link_enable,
  output logic host_mode
);
  import uoirs_pkg::*;

  initial begin
    if (NUM_EP < `UOIRS_COMB_EPS || NUM_EP > 16) begin
      $error("NUM_EP must lie between 4 and 16");
    end
  end

  // ********
  // Pin synchronisers
  // ********
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  wire logic cable_present_s = pin_s2_r[0];
  wire logic cable_a_s = pin_s2_r[1];
  wire logic suspend_s = pin_s2_r[2];
  wire logic peer_attach_s = pin_s2_r[3];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {peer_attach_seen, bus_suspend_seen, cable_a_side,
                   cable_present};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ********
  // Register decode
  // ********
  wire logic rd_comb = reg_rd && (reg_addr == `UOIRS_ADDR_COMBINED);
  wire logic rd_ctrl = reg_rd && (reg_addr == `UOIRS_ADDR_CTRL_STAT);
  wire logic rd_ep = reg_rd && (reg_addr == `UOIRS_ADDR_EP_STAT);
  wire logic wr_ctrl_en = reg_wr && (reg_addr == `UOIRS_ADDR_CTRL_EN);
  wire logic wr_ep_en = reg_wr && (reg_addr == `UOIRS_ADDR_EP_EN);
  wire logic wr_comb_en = reg_wr && (reg_addr == `UOIRS_ADDR_COMB_EN);
  wire logic wr_otg = reg_wr && (reg_addr == `UOIRS_ADDR_OTG_CTRL);

  logic [`UOIRS_NUM_EVENTS-1:0] ctrl_en_r;
  logic [31:0] ep_en_r;
  logic [`UOIRS_CEN_WIDTH-1:0] comb_en_r;
  logic [`UOIRS_OC_WIDTH-1:0] otg_ctrl_r;

  // ********
  // Operating state
  // ********
  logic phy_on_r;
  uoirs_otg_role_type role_r;
  uoirs_otg_role_type role_nxt;
  uoirs_neg_state_type neg_r;
  uoirs_neg_state_type neg_nxt;
  logic suspend_d_r;
  logic attach_d_r;

  wire logic phy_off_req = otg_ctrl_r[`UOIRS_OC_PHY_OFF];
  wire logic neg_en = otg_ctrl_r[`UOIRS_OC_NEG_EN];
  wire logic otg_sess = otg_ctrl_r[`UOIRS_OC_OTG_SESS];
  wire logic sw_reset = otg_ctrl_r[`UOIRS_OC_BUS_RESET];
  wire logic sw_suspend = otg_ctrl_r[`UOIRS_OC_BUS_SUSPEND];
  wire logic suspend_rise = suspend_s && !suspend_d_r;
  wire logic attach_rise = peer_attach_s && !attach_d_r;
  wire logic is_host = (role_r == role_a_host) || (role_r == role_b_host);
  wire logic is_dev = (role_r == role_a_peripheral) ||
                      (role_r == role_b_peripheral);

  // ********
  // Event sources
  // ********
  // While the transceiver is off no bus event reaches the flags.
  logic [`UOIRS_NUM_EVENTS-1:0] ev_valid;
  logic [`UOIRS_NUM_EVENTS-1:0] ev_set;
  wire logic neg_attach = (neg_r == neg_attempt) && attach_rise;
  always_comb begin
    ev_valid = {`UOIRS_NUM_EVENTS{1'b1}};
    ev_valid[`UOIRS_EV_POWER_ERR] = is_host; // R07
    ev_valid[`UOIRS_EV_SESS_BEGIN] = (role_r == role_a_host) ||
                                     (role_r == role_a_peripheral); // R07
    ev_valid[`UOIRS_EV_SESS_FINISH] = is_dev; // R07
    ev_valid[`UOIRS_EV_DETACH] = is_host; // R07
    ev_valid[`UOIRS_EV_ATTACH] = is_host; // R07
    ev_valid[`UOIRS_EV_OVERRUN] = is_host; // R08
    ev_valid[`UOIRS_EV_BUS_RESET] = is_dev; // R08
    ev_valid[`UOIRS_EV_IDLE] = is_dev; // R08
    ev_valid[`UOIRS_EV_ROLE_FOUND] = OTG_CAPABLE; // R09
    ev_valid[`UOIRS_EV_SUPPLY_FAULT] = is_host; // R09
    ev_set = phy_on_r ? (ctrl_event & ev_valid) : '0; // R19
    ev_set[`UOIRS_EV_ATTACH] = ev_set[`UOIRS_EV_ATTACH] || neg_attach; // R16
  end

  // ********
  // Sticky flag banks
  // ********
  uoirs_flag_if #(.W(`UOIRS_NUM_EVENTS)) ctrl_fl ();
  uoirs_flag_if #(.W(32)) ep_fl ();

  logic [15:0] ep_host_set;
  logic [15:0] ep_dev_set;
  always_comb begin
    ep_host_set = 16'h0000;
    ep_dev_set = 16'h0000;
    if (phy_on_r) begin
      ep_host_set[NUM_EP-1:0] = host_in_event | host_out_event;
      ep_dev_set[NUM_EP-1:0] = dev_in_event | dev_out_event;
    end
  end

  // Direction is kept apart in the combined view only.
  logic [`UOIRS_COMB_EPS*4-1:0] dir_pend_r;
  wire logic [`UOIRS_COMB_EPS*4-1:0] dir_set = phy_on_r ?
    {dev_out_event[`UOIRS_COMB_EPS-1:0], dev_in_event[`UOIRS_COMB_EPS-1:0],
     host_out_event[`UOIRS_COMB_EPS-1:0],
     host_in_event[`UOIRS_COMB_EPS-1:0]} : '0; // R03

  // A combined read clears general status and the four low endpoints.
  wire logic [31:0] comb_ep_mask = {{(16-`UOIRS_COMB_EPS){1'b0}},
    {`UOIRS_COMB_EPS{1'b1}}, {(16-`UOIRS_COMB_EPS){1'b0}},
    {`UOIRS_COMB_EPS{1'b1}}};
  assign ctrl_fl.set = ev_set;
  assign ctrl_fl.clr = (rd_ctrl || rd_comb) ?
                       {`UOIRS_NUM_EVENTS{1'b1}} : '0; // R02 R04
  assign ep_fl.set = {ep_dev_set, ep_host_set};
  assign ep_fl.clr = rd_ep ? 32'hffffffff :
                     (rd_comb ? comb_ep_mask : 32'h00000000); // R05

  uoirs_flag_bank #(.W(`UOIRS_NUM_EVENTS)) u_ctrl_bank (
    .core_clk(core_clk),
    .reset(reset),
    .fl(ctrl_fl)
  );
  uoirs_flag_bank #(.W(32)) u_ep_bank (
    .core_clk(core_clk),
    .reset(reset),
    .fl(ep_fl)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_pend_r <= '0;
    end else begin
      dir_pend_r <= (dir_pend_r & ~{(`UOIRS_COMB_EPS*4){rd_comb | rd_ep}})
                    | dir_set; // R21
    end
  end

  // ********
  // Combined view and interrupt
  // ********
  wire logic [4*`UOIRS_COMB_EPS-1:0] comb_ep = dir_pend_r; // R01 R03
  wire logic [31:0] comb_word = {{(32-`UOIRS_COMB_STAT_LSB
    -`UOIRS_NUM_EVENTS){1'b0}}, ctrl_fl.pend, comb_ep}; // R01
  wire logic [`UOIRS_COMB_EPS-1:0] hin = comb_ep[`UOIRS_COMB_HOST_IN_LSB +:
                                                 `UOIRS_COMB_EPS];
  wire logic [`UOIRS_COMB_EPS-1:0] hout = comb_ep[`UOIRS_COMB_HOST_OUT_LSB +:
                                                  `UOIRS_COMB_EPS];
  wire logic [`UOIRS_COMB_EPS-1:0] din = comb_ep[`UOIRS_COMB_DEV_IN_LSB +:
                                                 `UOIRS_COMB_EPS];
  wire logic [`UOIRS_COMB_EPS-1:0] dout = comb_ep[`UOIRS_COMB_DEV_OUT_LSB +:
                                                  `UOIRS_COMB_EPS];
  wire logic comb_hit = (comb_en_r[`UOIRS_CEN_HOST_IN] && |hin) ||
                        (comb_en_r[`UOIRS_CEN_HOST_OUT] && |hout) ||
                        (comb_en_r[`UOIRS_CEN_DEV_IN] && |din) ||
                        (comb_en_r[`UOIRS_CEN_DEV_OUT] && |dout) ||
                        (comb_en_r[`UOIRS_CEN_STATUS] && |ctrl_fl.pend);
  wire logic irq_nxt = |(ctrl_fl.pend & ctrl_en_r) ||
                       |(ep_fl.pend & ep_en_r) || comb_hit; // R06

  // ********
  // Role reporting
  // ********
  uoirs_dual_role_type dual_role;
  assign dual_role = !phy_on_r ? dual_none :
                     (is_host ? dual_host :
                     (is_dev ? dual_device : dual_none)); // R13
  wire logic [31:0] role_word = {26'h0000000, dual_role,
                                 1'b0, role_r}; // R10

  always_comb begin
    role_nxt = role_r;
    if (!phy_on_r || !otg_sess || !OTG_CAPABLE) begin
      role_nxt = role_undetermined; // R12
    end else if (!cable_present_s) begin
      role_nxt = role_b_peripheral; // R11
    end else if (cable_a_s) begin
      role_nxt = role_a_host;
    end else if (neg_r == neg_hosting) begin
      role_nxt = role_b_host;
    end else begin
      role_nxt = role_b_peripheral;
    end
  end

  // ********
  // Host negotiation
  // ********
  always_comb begin
    neg_nxt = neg_r;
    case (neg_r)
      neg_idle: begin
        if (neg_en && role_r == role_b_peripheral) begin
          neg_nxt = neg_armed; // R14
        end
      end
      neg_armed: begin
        if (!neg_en) begin
          neg_nxt = neg_idle; // R14
        end else if (suspend_rise) begin
          neg_nxt = neg_attempt; // R15
        end
      end
      neg_attempt: begin
        if (!neg_en) begin
          neg_nxt = neg_idle;
        end else if (attach_rise) begin
          neg_nxt = neg_hosting; // R16
        end
      end
      neg_hosting: begin
        if (sw_suspend) begin
          neg_nxt = neg_idle; // R18
        end
      end
      default: begin
        neg_nxt = neg_idle;
      end
    endcase
    if (!phy_on_r || role_r == role_undetermined) begin
      neg_nxt = neg_idle;
    end
  end

  // Reset stays driven after a negotiated attach until software, having
  // waited its 20 ms, drops the bus reset bit.
  logic auto_reset_r;
  wire logic rst_kept = !wr_otg || reg_wdata[`UOIRS_OC_BUS_RESET];
  wire logic auto_reset_nxt = neg_attach ||
    (auto_reset_r && rst_kept && neg_r == neg_hosting); // R17

  // ********
  // Registers and read port
  // ********
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `UOIRS_ADDR_COMBINED: rdata_nxt = comb_word;
        `UOIRS_ADDR_CTRL_STAT: rdata_nxt[`UOIRS_NUM_EVENTS-1:0] =
                                 ctrl_fl.pend; // R04
        `UOIRS_ADDR_EP_STAT: rdata_nxt = ep_fl.pend; // R05
        `UOIRS_ADDR_CTRL_EN: rdata_nxt[`UOIRS_NUM_EVENTS-1:0] = ctrl_en_r;
        `UOIRS_ADDR_EP_EN: rdata_nxt = ep_en_r;
        `UOIRS_ADDR_COMB_EN: rdata_nxt[`UOIRS_CEN_WIDTH-1:0] = comb_en_r;
        `UOIRS_ADDR_OTG_CTRL: rdata_nxt[`UOIRS_OC_WIDTH-1:0] = otg_ctrl_r;
        `UOIRS_ADDR_ROLE: rdata_nxt = role_word;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_en_r <= '0;
      ep_en_r <= 32'h00000000;
      comb_en_r <= '0;
      otg_ctrl_r <= '0;
      reg_rdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl_en) ctrl_en_r <= reg_wdata[`UOIRS_NUM_EVENTS-1:0];
      if (wr_ep_en) ep_en_r <= reg_wdata; // R06
      if (wr_comb_en) comb_en_r <= reg_wdata[`UOIRS_CEN_WIDTH-1:0];
      if (wr_otg) otg_ctrl_r <= reg_wdata[`UOIRS_OC_WIDTH-1:0];
      reg_rdata <= rdata_nxt;
      irq <= irq_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      phy_on_r <= 1'b1; // R20
      role_r <= role_undetermined;
      neg_r <= neg_idle;
      suspend_d_r <= 1'b0;
      attach_d_r <= 1'b0;
      auto_reset_r <= 1'b0;
      bus_reset_drive <= 1'b0;
      bus_suspend_drive <= 1'b0;
      phy_power_on <= 1'b1;
      link_enable <= 1'b1;
      host_mode <= 1'b0;
    end else begin
      phy_on_r <= !phy_off_req; // R19 R20
      role_r <= role_nxt;
      neg_r <= neg_nxt;
      suspend_d_r <= suspend_s;
      attach_d_r <= peer_attach_s;
      auto_reset_r <= auto_reset_nxt;
      bus_reset_drive <= phy_on_r && (auto_reset_nxt || sw_reset); // R16
      bus_suspend_drive <= phy_on_r && sw_suspend; // R18
      phy_power_on <= !phy_off_req; // R19
      link_enable <= !phy_off_req; // R19
      host_mode <= is_host && !phy_off_req; // R19
    end
  end
endmodule
`default_nettype wire

// ---- sim/uoirs_checker.sv ----
/*
 Concurrent checks of the interrupt-status and role block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module uoirs_checker #(
  parameter int NUM_EP = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [11:0] ctrl_event,
  input wire logic [NUM_EP-1:0] host_in_event,
  input wire logic [NUM_EP-1:0] host_out_event,
  input wire logic [NUM_EP-1:0] dev_in_event,
  input wire logic [NUM_EP-1:0] dev_out_event,
  input wire logic irq,
  input wire logic bus_reset_drive,
  input wire logic phy_power_on,
  input wire logic link_enable,
  input wire logic host_mode
);
  // ********
  // Helper logic
  // ********
  localparam logic [11:0] ANY_ROLE = 12'h120;
  logic acc_r;
  logic [2:0] since_clr_r;
  logic [2:0] since_clr_nxt;
  wire clr_wr = reg_wr && reg_addr == 4'h6 && !reg_wdata[3];
  wire ep_busy = |{host_in_event, host_out_event, dev_in_event, dev_out_event};
  wire quiet = ctrl_event == 12'h0 && !ep_busy;
  assign since_clr_nxt = clr_wr ? 3'h0 :
                         (since_clr_r == 3'h7 ? 3'h7 : since_clr_r + 3'h1);
  always_ff @(posedge core_clk) begin
    acc_r <= reg_rd || reg_wr;
    since_clr_r <= reset ? 3'h7 : since_clr_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_read(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // A read with no event arriving, then a quiet gap cycle.
  sequence s_quiet_read(logic [3:0] a);
    reg_rd && reg_addr == a && quiet ##1 quiet;
  endsequence
  sequence s_event_read;
    reg_rd && reg_addr == 4'h1 && phy_power_on &&
    (ctrl_event & ANY_ROLE) != 12'h0;
  endsequence
  // ********
  // Assertions
  // ********
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("stray read data");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr[3] |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_clear: assert property (
    s_quiet_read(4'h1) ##1 s_read(4'h1) |=> reg_rdata[11:0] == 12'h0)
    else $error("control read kept flags");
  chk_comb_clear: assert property (
    s_quiet_read(4'h0) ##1 s_read(4'h1) |=> reg_rdata[11:0] == 12'h0)
    else $error("combined read kept flags");
  chk_ep_clear: assert property (
    s_quiet_read(4'h2) ##1 s_read(4'h2) |=> reg_rdata == 32'h0)
    else $error("endpoint read kept flags");
  chk_set_survives: assert property (
    s_event_read ##1 s_read(4'h1) |=>
    (reg_rdata[11:0] & $past(ctrl_event, 2) & ANY_ROLE) ==
    ($past(ctrl_event, 2) & ANY_ROLE))
    else $error("event lost at clear");
  chk_reset_values: assert property (disable iff (1'b0) reset |=>
    phy_power_on && link_enable && !irq && !bus_reset_drive && !host_mode)
    else $error("outputs wrong after reset");
  chk_phy_off: assert property (
    !phy_power_on |-> !link_enable && !host_mode)
    else $error("link active with transceiver off");
  chk_reset_hold: assert property (
    $fell(bus_reset_drive) |-> since_clr_r <= 3'h3)
    else $error("reset dropped unasked");
  chk_irq_fall: assert property ($fell(irq) |-> acc_r || $past(acc_r))
    else $error("irq fell unasked");
endmodule
bind uoirs_top uoirs_checker #(.NUM_EP(NUM_EP)) u_chk (
  .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .ctrl_event, .host_in_event, .host_out_event, .dev_in_event,
  .dev_out_event, .irq, .bus_reset_drive, .phy_power_on, .link_enable,
  .host_mode);
`default_nettype wire

// ---- sim/uoirs_far_end.sv ----
/*
 Model of the peer across the cable: cable pins and bus conditions.
 Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
`default_nettype none
module uoirs_far_end (
  input wire logic core_clk,
  input wire logic bus_suspend_drive,
  output logic cable_present,
  output logic cable_a_side,
  output logic bus_suspend_seen,
  output logic peer_attach_seen
);
  initial begin
    cable_present = 1'b0;
    cable_a_side = 1'b0;
    bus_suspend_seen = 1'b0;
    peer_attach_seen = 1'b0;
  end
  task automatic plug(input logic p, input logic a);
    @(posedge core_clk);
    cable_present <= p;
    cable_a_side <= a;
  endtask
  // The bus goes idle first; only then does the peer attach as a device.
  task automatic negotiate();
    @(posedge core_clk);
    bus_suspend_seen <= 1'b1;
    repeat (4) @(posedge core_clk);
    peer_attach_seen <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic withdraw();
    @(posedge core_clk);
    bus_suspend_seen <= 1'b0;
    peer_attach_seen <= 1'b0;
  endtask
  // A suspend from the new host hands the bus back to the A-side.
  always @(posedge core_clk) begin
    if (bus_suspend_drive) begin
      bus_suspend_seen <= 1'b0;
      peer_attach_seen <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/usb_otg_irq_and_role_status_bench.sv ----
/*
 Self-checking bench for the interrupt-status and role block.
 Assumes the far-end model drives the cable and bus level pins.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_otg_irq_and_role_status_bench;
  logic core_clk, reset, reg_wr, reg_rd, irq, bus_reset_drive;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [11:0] ctrl_event;
  logic [15:0] host_in_event, host_out_event, dev_in_event, dev_out_event;
  logic cable_present, cable_a_side, bus_suspend_seen, peer_attach_seen;
  logic bus_suspend_drive, phy_power_on, link_enable, host_mode;
  int err_count, comparisons;
  uoirs_top #(.NUM_EP(16), .OTG_CAPABLE(1'b1)) u_dut (
    .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ctrl_event, .host_in_event, .host_out_event, .dev_in_event,
    .dev_out_event, .cable_present, .cable_a_side, .bus_suspend_seen,
    .peer_attach_seen, .irq, .bus_reset_drive, .bus_suspend_drive,
    .phy_power_on, .link_enable, .host_mode);
  uoirs_far_end u_far (.core_clk, .bus_suspend_drive, .cable_present,
    .cable_a_side, .bus_suspend_seen, .peer_attach_seen);
  // ********
  // Bus tasks
  // ********
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bit_is(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, d & m);
  endtask
  task automatic ev(input logic [11:0] e);
    @(posedge core_clk);
    ctrl_event <= e;
    @(posedge core_clk);
    ctrl_event <= 12'h0;
  endtask
  task automatic ep_pulse(input logic [63:0] m);
    @(posedge core_clk);
    {host_in_event, host_out_event, dev_in_event, dev_out_event} <= m;
    @(posedge core_clk);
    {host_in_event, host_out_event, dev_in_event, dev_out_event} <= 64'h0;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_reset_state();
    w(1);
    bit_is("power", 1'b1, phy_power_on);
    rc(4'h6, 32'hffff_ffff, 32'h0, "otg control");
    rc(4'h7, 32'h3f, 32'h0, "role");
    wr(4'h9, 32'hffff_ffff);
    rc(4'h9, 32'hffff_ffff, 32'h0, "unmapped");
  endtask
  task automatic t_roles();
    wr(4'h6, 32'h4);
    w(5);
    rc(4'h7, 32'h3f, 32'h24, "role");
    u_far.plug(1'b1, 1'b1);
    w(5);
    rc(4'h7, 32'h3f, 32'h11, "role");
    bit_is("host mode", 1'b1, host_mode);
    rd(4'h1);
    ev(12'hfff);
    rc(4'h1, 32'hfff, 32'hd7b, "host events");
    rc(4'h1, 32'hfff, 32'h0, "cleared");
    u_far.plug(1'b1, 1'b0);
    w(5);
    rc(4'h7, 32'h3f, 32'h24, "role");
    rd(4'h1);
    ev(12'hfff);
    rc(4'h1, 32'hfff, 32'h7a4, "device events");
    wr(4'h6, 32'h6);
    w(5);
    rc(4'h7, 32'h3f, 32'h0, "role");
    bit_is("link", 1'b0, link_enable);
    ev(12'hfff);
    wr(4'h6, 32'h4);
    w(5);
    rc(4'h1, 32'hfff, 32'h0, "events while off");
    bit_is("link", 1'b1, link_enable);
  endtask
  task automatic t_combined();
    rd(4'h1);
    ep_pulse({32'h0, 16'h0024, 16'h0002});
    ev(12'h020);
    rc(4'h0, 32'hffff_ffff, 32'h0020_2400, "combined");
    rc(4'h1, 32'hfff, 32'h0, "control");
    rc(4'h2, 32'hffff_ffff, 32'h0020_0000, "endpoint");
    rc(4'h2, 32'hffff_ffff, 32'h0, "endpoint");
    @(posedge core_clk);
    reg_addr <= 4'h1;
    reg_rd <= 1'b1;
    ctrl_event <= 12'h100;
    @(posedge core_clk);
    ctrl_event <= 12'h0;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("kept event", 32'h100, reg_rdata);
  endtask
  task automatic t_irq();
    wr(4'h5, 32'h1f);
    wr(4'h4, 32'h0020_0000);
    ep_pulse({32'h0, 16'h0040, 16'h0});
    w(3);
    bit_is("irq", 1'b0, irq);
    ep_pulse({32'h0, 16'h0020, 16'h0});
    w(3);
    bit_is("irq", 1'b1, irq);
    rc(4'h2, 32'hffff_ffff, 32'h0060_0000, "endpoint");
    w(3);
    bit_is("irq", 1'b0, irq);
    wr(4'h3, 32'h20);
    ev(12'h020);
    w(3);
    bit_is("irq", 1'b1, irq);
    rd(4'h1);
    w(3);
    bit_is("irq", 1'b0, irq);
    wr(4'h3, 32'h0);
    wr(4'h4, 32'h0);
  endtask
  task automatic t_hnp();
    u_far.negotiate();
    w(3);
    bit_is("bus reset", 1'b0, bus_reset_drive);
    u_far.withdraw();
    w(4);
    rd(4'h1);
    wr(4'h6, 32'h5);
    u_far.negotiate();
    w(3);
    bit_is("bus reset", 1'b1, bus_reset_drive);
    bit_is("host mode", 1'b1, host_mode);
    rc(4'h7, 32'h3f, 32'h13, "role");
    rc(4'h1, 32'hfff, 32'h010, "attach");
    // Held only briefly here; the long hold is left to software.
    wr(4'h6, 32'h5);
    w(3);
    bit_is("bus reset", 1'b0, bus_reset_drive);
    wr(4'h6, 32'h15);
    w(5);
    bit_is("host mode", 1'b0, host_mode);
    bit_is("bus suspend", 1'b1, bus_suspend_drive);
    rc(4'h7, 32'h3f, 32'h24, "role");
    wr(4'h6, 32'h4);
  endtask
  // ********
  // Run control
  // ********
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    stop_test();
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, ctrl_event} = '0;
    {host_in_event, host_out_event, dev_in_event, dev_out_event} = '0;
    err_count = 0;
    comparisons = 0;
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_state();
    t_roles();
    t_combined();
    t_irq();
    t_hnp();
    stop_test();
  end
endmodule
`default_nettype wire
